// File: fsp_pkg.sv
package fsp_pkg;
  // status word bit positions
  localparam int unsigned BIT_BUSY     = 0;
  localparam int unsigned BIT_WEL      = 1;
  localparam int unsigned BIT_SEL_LO   = 2;
  localparam int unsigned BIT_SEL_HI   = 6;
  localparam int unsigned BIT_MODE_LO  = 7;
  localparam int unsigned BIT_MODE_HI  = 8;
  localparam int unsigned BIT_QUAD     = 9;
  localparam int unsigned BIT_PPAUSE   = 10;
  localparam int unsigned BIT_LOCK_LO  = 11;
  localparam int unsigned BIT_LOCK_HI  = 13;
  localparam int unsigned BIT_INVERT   = 14;
  localparam int unsigned BIT_EPAUSE   = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE_CMD   = 8'h06;
  localparam logic [7:0] CMD_WRDI   = 8'h04;
  localparam logic [7:0] CMD_RDLO   = 8'h05;
  localparam logic [7:0] CMD_RDHI   = 8'h35;
  localparam logic [7:0] CMD_STATUS_WRITE_CMD   = 8'h01;
  localparam logic [7:0] CMD_PP     = 8'h02;
  localparam logic [7:0] CMD_QPP    = 8'h32;
  localparam logic [7:0] CMD_SE     = 8'h20;
  localparam logic [7:0] CMD_BE32   = 8'h52;
  localparam logic [7:0] CMD_BE64   = 8'hD8;
  localparam logic [7:0] CMD_CE1    = 8'hC7;
  localparam logic [7:0] CMD_CE2    = 8'h60;
  localparam logic [7:0] CMD_SUSP   = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_RSTEN  = 8'h66;
  localparam logic [7:0] CMD_RST    = 8'h99;
  localparam logic [7:0] CMD_SRP    = 8'h42;
  localparam logic [7:0] CMD_SRE    = 8'h44;
  // array geometry: 22 address bits, 64KB blocks, 4KB sectors
  localparam int unsigned ADDR_W = 22;
  // status write busy time
  localparam int unsigned STATUS_WRITE_NS = 5000;
  localparam int unsigned CLK_NS          = 5;
  localparam int unsigned STATUS_WRITE_CYC = (STATUS_WRITE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {FSP_OP_NONE, FSP_OP_PROG, FSP_OP_ERASE, FSP_OP_CHIP} fsp_op_t;
endpackage : fsp_pkg

// File: fsp_link.sv
`timescale 1ns/1ps
`default_nettype none
// serial-clock side: shifts command bytes, hands whole commands across by toggle
module fsp_link
  import fsp_pkg::*;
(
  input  wire logic        i_sclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  input  wire logic [15:0] i_status,
  output logic             o_so,
  output logic [7:0]       o_cmd,
  output logic [23:0]      o_addr,
  output logic [15:0]      o_data,
  output logic [2:0]       o_nbytes,
  output logic             o_tgl
);
  logic [7:0]  sh_q;
  logic [2:0]  bit_q;
  logic [2:0]  byte_q;
  logic [7:0]  out_q;
  logic [15:0] st_q;
  // commands are handed over at the rising edge of chip select; sclk may stop
  // afterwards, so the capture regs are held until the next frame shifts in their bytes
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_q  <= 3'h0;
      byte_q <= 3'h0;
      sh_q   <= 8'h00;
    end else begin
      sh_q  <= {sh_q[6:0], i_si};
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        if (byte_q != 3'h7) begin
          byte_q <= byte_q + 3'h1;
        end
      end
    end
  end
  // capture regs carry no reset, so they sit in a process of their own
  always_ff @(posedge i_sclk) begin
    if (!i_cs_n) begin
      if (bit_q == 3'h7) begin
        case (byte_q)
          3'h0: o_cmd <= {sh_q[6:0], i_si};
          3'h1: begin
            o_addr[23:16] <= {sh_q[6:0], i_si};
            o_data[7:0]   <= {sh_q[6:0], i_si};
          end
          3'h2: begin
            o_addr[15:8] <= {sh_q[6:0], i_si};
            o_data[15:8] <= {sh_q[6:0], i_si};
          end
          3'h3: o_addr[7:0] <= {sh_q[6:0], i_si};
          default: ;
        endcase
      end
    end
  end
  // byte count and handover toggle taken as chip select rises, a partial last byte giving count zero;
  // reset is only released while chip select is high and sclk idle
  always_ff @(posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nbytes <= 3'h0;
      o_tgl    <= 1'b0;
    end else begin
      o_nbytes <= (bit_q == 3'h0) ? byte_q : 3'h0;
      o_tgl    <= ~o_tgl;
    end
  end
  // read data shifted out on the falling edge; the first bit comes straight
  // from the live word, the old snapshot would be one frame stale
  always_ff @(negedge i_sclk) begin
    if (bit_q == 3'h0 && byte_q == 3'h1) begin
      st_q <= i_status;
      o_so <= (o_cmd == CMD_RDLO) ? i_status[7] : i_status[15];
    end else if (o_cmd == CMD_RDLO) begin
      o_so <= st_q[4'h7 - {1'b0, bit_q}];
    end else begin
      o_so <= st_q[4'hF - {1'b0, bit_q}];
    end
  end
endmodule : fsp_link
`default_nettype wire

// File: fsp_status.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - busy high during program, erase, status write
// - write latch clear refuses writes, programs, erases
// - protect select bits change only by status write
// - block program and erase in protected range
// - protect select writable only in mode 00, or mode 01 with pin high
// - chip erase only for 000/normal or 111/inverted
// - inverted mode protects complement of normal area
// - lock mode bits select status write protection
// - mode 00 status writable whenever latch set
// - mode 01 low protect pin locks status
// - mode 10 locks until power cycle, then 00
// - mode 11 refuses status writes until reset
// - quad bit swaps protect/hold pins for data
// - security lock bits set once, stay set until reset
// - invert bit is stored, readable, default zero
// - suspend sets erase or program paused flag
// - resume or software reset clears paused flags
// - write latch cleared by listed commands
// - quad commands only while quad bit set
module fsp_status
  import fsp_pkg::*;
#(
  parameter int unsigned WRITE_CYC = STATUS_WRITE_CYC,
  parameter int unsigned OP_CYC    = 64
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  input  wire logic        i_wp_n,
  input  wire logic        i_op_done,
  output logic             o_so,
  output logic [15:0]      o_status,
  output logic             o_quad_pins,
  output logic             o_quad_ok,
  output logic             o_op_start,
  output fsp_pkg::fsp_op_t o_op_kind,
  output logic [23:0]      o_op_addr,
  output logic             o_op_refused
);
  import fsp_pkg::*;
  typedef enum {FSP_IDLE, FSP_WRSTAT, FSP_ARRAY} fsp_state_t;

  logic [7:0]  l_cmd;
  logic [23:0] l_addr;
  logic [15:0] l_data;
  logic [2:0]  l_nbytes;
  logic        l_tgl;
  logic [2:0]  tgl_q;
  logic [2:0]  wp_q;
  logic        wp_lvl_q, wp_lvl_d;
  logic        ev;

  fsp_link u_link (
    .i_sclk   (i_sclk),
    .i_rst_n  (i_rst_n),
    .i_cs_n   (i_cs_n),
    .i_si     (i_si),
    .i_status (o_status),
    .o_so     (o_so),
    .o_cmd    (l_cmd),
    .o_addr   (l_addr),
    .o_data   (l_data),
    .o_nbytes (l_nbytes),
    .o_tgl    (l_tgl)
  );

  // toggle crossing: bus words are stable long before the toggle is seen
  always_ff @(posedge i_clk) begin
    tgl_q    <= {tgl_q[1:0], l_tgl};
    wp_q     <= {wp_q[1:0], i_wp_n};
    wp_lvl_q <= wp_lvl_d;
  end
  always_comb begin
    wp_lvl_d = wp_lvl_q;
    if (wp_q[1] == wp_q[2]) begin
      wp_lvl_d = wp_q[2];
    end
  end
  assign ev = tgl_q[1] ^ tgl_q[2];

  logic [15:0] st_q, st_d;
  logic [15:0] pend_q, pend_d;
  logic        rsten_q, rsten_d;
  logic        boot_q, boot_d;
  logic [15:0] cnt_q, cnt_d;
  fsp_state_t  state_q, state_d;
  logic        start_d;
  fsp_op_t     kind_q, kind_d;
  logic [23:0] addr_q, addr_d;
  logic        ref_d;

  logic [4:0]  sel;
  logic [1:0]  mode;
  logic        inv;
  logic        stat_ok;
  logic        prot;
  logic        write_latch_flag;

  assign sel  = st_q[BIT_SEL_HI:BIT_SEL_LO];
  assign mode = st_q[BIT_MODE_HI:BIT_MODE_LO];
  assign inv  = st_q[BIT_INVERT];
  assign write_latch_flag  = st_q[BIT_WEL];

  always_comb begin
    case (mode)
      2'b00:   stat_ok = 1'b1;
      2'b01:   stat_ok = wp_lvl_q;
      default: stat_ok = 1'b0;
    endcase
  end

  // normal-mode area, inverted when the invert bit is set
  function automatic logic in_area(input logic [4:0] s, input logic [23:0] a);
    logic       hit;
    logic [5:0] blk;
    logic [2:0] sec;
    hit = 1'b0;
    blk = a[21:16];
    sec = a[14:12];
    if (s[2:0] == 3'b111) begin
      hit = 1'b1;
    end else if (s[2:0] == 3'b000) begin
      hit = 1'b0;
    end else if (!s[4]) begin
      // fraction: 1 << (code-1) blocks, code 6 is half the array
      if (s[3]) begin
        hit = (blk >> (s[2:0] - 3'h1)) == 6'h00;
      end else begin
        hit = ((~blk) >> (s[2:0] - 3'h1)) == 6'h00;
      end
    end else begin
      // small sector ranges inside top or bottom block, capped at 32KB
      if (s[3]) begin
        hit = (blk == 6'h00) && (a[15] == 1'b0) &&
              (({1'b0, a[14:12]} >> (s[2] ? 3'h3 : (s[1:0] - 2'h1))) == 4'h0);
      end else begin
        hit = (blk == 6'h3F) && (a[15] == 1'b1) &&
              (({1'b0, ~sec} >> (s[2] ? 3'h3 : (s[1:0] - 2'h1))) == 4'h0);
      end
    end
    return hit;
  endfunction

  assign prot = in_area(sel, l_addr) ^ inv;

  always_comb begin
    st_d    = st_q;
    pend_d  = pend_q;
    rsten_d = rsten_q;
    boot_d  = 1'b1;
    cnt_d   = cnt_q;
    state_d = state_q;
    start_d = 1'b0;
    kind_d  = kind_q;
    addr_d  = addr_q;
    ref_d   = 1'b0;
    // nothing is restored on power-up, reset zeroes the whole status word; mode 10 returns 00
    if (!boot_q && st_q[BIT_MODE_HI:BIT_MODE_LO] == 2'b10) begin
      st_d[BIT_MODE_HI:BIT_MODE_LO] = 2'b00;
    end
    case (state_q)
      FSP_WRSTAT: begin
        cnt_d = cnt_q - 16'h1;
        if (cnt_q == 16'h0) begin
          st_d[BIT_MODE_LO:BIT_SEL_LO] = pend_q[BIT_MODE_LO:BIT_SEL_LO];
          st_d[BIT_MODE_HI]  = pend_q[BIT_MODE_HI];
          st_d[BIT_QUAD]     = pend_q[BIT_QUAD];
          st_d[BIT_INVERT]   = pend_q[BIT_INVERT];
          st_d[BIT_LOCK_HI:BIT_LOCK_LO] = st_q[BIT_LOCK_HI:BIT_LOCK_LO] |
                                          pend_q[BIT_LOCK_HI:BIT_LOCK_LO];
          st_d[BIT_BUSY] = 1'b0;
          st_d[BIT_WEL]  = 1'b0;
          state_d = FSP_IDLE;
        end
      end
      FSP_ARRAY: begin
        if (i_op_done) begin
          st_d[BIT_BUSY] = 1'b0;
          state_d = FSP_IDLE;
        end
      end
      default: ;
    endcase
    if (ev) begin
      rsten_d = (l_cmd == CMD_RSTEN) && (l_nbytes == 3'h1);
      if (l_nbytes != 3'h0) begin
        if (l_cmd == CMD_RST && rsten_q) begin
          st_d[BIT_EPAUSE] = 1'b0;
          st_d[BIT_PPAUSE] = 1'b0;
          st_d[BIT_WEL]    = 1'b0;
        end else if (l_cmd == CMD_RESUME) begin
          st_d[BIT_EPAUSE] = 1'b0;
          st_d[BIT_PPAUSE] = 1'b0;
        end else if (l_cmd == CMD_SUSP && state_q == FSP_ARRAY) begin
          if (kind_q == FSP_OP_PROG) begin
            st_d[BIT_PPAUSE] = 1'b1;
          end else begin
            st_d[BIT_EPAUSE] = 1'b1;
          end
        end else if (!st_q[BIT_BUSY]) begin
          if (l_cmd == CMD_WRITE_ENABLE_CMD) begin
            st_d[BIT_WEL] = 1'b1;
          end else if (l_cmd == CMD_WRDI) begin
            st_d[BIT_WEL] = 1'b0;
          end else if (l_cmd == CMD_STATUS_WRITE_CMD && l_nbytes >= 3'h2) begin
            if (write_latch_flag && stat_ok) begin
              pend_d = (l_nbytes == 3'h2) ? {st_q[15:8], l_data[7:0]} : l_data;
              st_d[BIT_BUSY] = 1'b1;
              cnt_d   = 16'(WRITE_CYC - 1);
              state_d = FSP_WRSTAT;
            end else begin
              ref_d = 1'b1;
            end
          end else if (l_cmd == CMD_CE1 || l_cmd == CMD_CE2) begin
            if (write_latch_flag && ((sel[2:0] == 3'b000 && !inv) ||
                        (sel[2:0] == 3'b111 && inv))) begin
              st_d[BIT_WEL] = 1'b0;
              st_d[BIT_BUSY] = 1'b1;
              start_d = 1'b1;
              kind_d  = FSP_OP_CHIP;
              state_d = FSP_ARRAY;
            end else begin
              ref_d = 1'b1;
            end
          end else if (l_cmd == CMD_PP || l_cmd == CMD_QPP || l_cmd == CMD_SE ||
                       l_cmd == CMD_BE32 || l_cmd == CMD_BE64 ||
                       l_cmd == CMD_SRP || l_cmd == CMD_SRE) begin
            if (write_latch_flag && !prot && l_nbytes >= 3'h4 &&
                (l_cmd != CMD_QPP || st_q[BIT_QUAD])) begin
              st_d[BIT_WEL] = 1'b0;
              st_d[BIT_BUSY] = 1'b1;
              start_d = 1'b1;
              kind_d  = (l_cmd == CMD_PP || l_cmd == CMD_QPP) ? FSP_OP_PROG : FSP_OP_ERASE;
              addr_d  = l_addr;
              state_d = FSP_ARRAY;
            end else begin
              ref_d = 1'b1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q    <= STATUS_RESET;
      pend_q  <= STATUS_RESET;
      rsten_q <= 1'b0;
      boot_q  <= 1'b0;
      cnt_q   <= 16'h0;
      state_q <= FSP_IDLE;
      kind_q  <= FSP_OP_NONE;
      addr_q  <= 24'h000000;
      o_op_start   <= 1'b0;
      o_op_refused <= 1'b0;
    end else begin
      st_q    <= st_d;
      pend_q  <= pend_d;
      rsten_q <= rsten_d;
      boot_q  <= boot_d;
      cnt_q   <= cnt_d;
      state_q <= state_d;
      kind_q  <= kind_d;
      addr_q  <= addr_d;
      o_op_start   <= start_d;
      o_op_refused <= ref_d;
    end
  end

  assign o_status    = st_q;
  assign o_op_kind   = kind_q;
  assign o_op_addr   = addr_q;
  assign o_quad_pins = st_q[BIT_QUAD];
  assign o_quad_ok   = st_q[BIT_QUAD];

  property p_busy_status_write_cmd;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == FSP_WRSTAT) |-> st_q[BIT_BUSY];
  endproperty
  a_busy_status_write_cmd: assert property (p_busy_status_write_cmd) else $error("busy low in status write");

  property p_wel_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_op_start || $rose(st_q[BIT_BUSY])) |-> $past(st_q[BIT_WEL]);
  endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("op started without latch");

  property p_wel_clears;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_op_start |-> !st_q[BIT_WEL];
  endproperty
  a_wel_clears: assert property (p_wel_clears) else $error("latch kept after op");

  property p_lock_sticky;
    @(posedge i_clk) disable iff (!i_rst_n)
      ($past(st_q[BIT_LOCK_HI:BIT_LOCK_LO]) & ~st_q[BIT_LOCK_HI:BIT_LOCK_LO]) == 3'h0;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

  property p_otp;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == FSP_WRSTAT && $past(state_q) == FSP_IDLE) |->
        ($past(mode) != 2'b11 && $past(mode) != 2'b10);
  endproperty
  a_otp: assert property (p_otp) else $error("write in locked mode");

  property p_hw_lock;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == FSP_WRSTAT && $past(state_q) == FSP_IDLE && $past(mode) == 2'b01) |->
        $past(wp_lvl_q);
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("write with pin low");

  property p_status_write_cmd_len;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_q == FSP_WRSTAT && $past(state_q) == FSP_IDLE) |->
        ##[1:1000] (state_q == FSP_IDLE || cnt_q > 16'd1000);
  endproperty
  a_status_write_cmd_len: assert property (p_status_write_cmd_len) else $error("status write hung");

  property p_chip_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_op_start && o_op_kind == FSP_OP_CHIP) |->
        ((sel[2:0] == 3'b000 && !inv) || (sel[2:0] == 3'b111 && inv));
  endproperty
  a_chip_gate: assert property (p_chip_gate) else $error("chip erase while protected");
endmodule : fsp_status
`default_nettype wire

// File: fsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// spi host, mode 0: sclk idles low and runs only inside frames
module fsp_host_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  localparam int HALF_NS = 6;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  // whole bytes only, msb first; read bytes follow the written ones
  task automatic frame(input logic [39:0] data, input int nwr, input int nrd,
                       output logic [7:0] rd);
    int i;
    rd = 8'h00;
    o_cs_n = 1'b0;
    #(HALF_NS);
    for (i = 0; i < 8 * (nwr + nrd); i++) begin
      o_si = (i < 8 * nwr) ? data[39-i] : ~o_si;
      #(HALF_NS);
      o_sclk = 1'b1;
      if (i >= 8 * nwr) rd = {rd[6:0], i_so};
      #(HALF_NS);
      o_sclk = 1'b0;
    end
    #(HALF_NS);
    o_cs_n = 1'b1;
    // released line must not keep showing the last bit
    o_si = ~o_si;
  endtask : frame
endmodule : fsp_host_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fsp_pkg::*;
  localparam int unsigned WCYC = 8;
  logic        i_clk;
  logic        i_rst_n;
  logic        i_wp_n;
  logic        i_op_done;
  wire         sclk;
  wire         cs_n;
  wire         si;
  logic        so;
  logic [15:0] status;
  logic        quad_pins;
  logic        quad_ok;
  logic        op_start;
  logic        op_refused;
  fsp_op_t     op_kind;
  logic [23:0] op_addr;
  fsp_op_t     last_kind;
  logic [23:0] last_addr;
  logic [7:0]  rd;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          ref_cnt = 0;
  int          start_cnt = 0;

  // short write time keeps the run small; expectations use WCYC
  fsp_status #(.WRITE_CYC(WCYC), .OP_CYC(64)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
    .i_wp_n(i_wp_n), .i_op_done(i_op_done), .o_so(so), .o_status(status),
    .o_quad_pins(quad_pins), .o_quad_ok(quad_ok), .o_op_start(op_start),
    .o_op_kind(op_kind), .o_op_addr(op_addr), .o_op_refused(op_refused));
  fsp_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // one-cycle pulses are counted in the cycle they stand
  always @(posedge i_clk) begin
    if (op_refused === 1'b1) ref_cnt++;
    if (op_start === 1'b1) begin
      start_cnt++;
      last_kind = op_kind;
      last_addr = op_addr;
    end
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic send(input logic [39:0] d, input int nb);
    u_host.frame(d, nb, 0, rd);
    cyc(12);
  endtask : send
  task automatic op1(input logic [7:0] c);
    send({c, 32'h0}, 1);
  endtask : op1
  task automatic status_write_cmd(input logic [7:0] lo, input logic [7:0] hi);
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_STATUS_WRITE_CMD, lo, hi, 16'h0}, 3);
    cyc(WCYC + 10);
  endtask : status_write_cmd
  task automatic done_op;
    i_op_done = 1'b1;
    cyc(1);
    i_op_done = 1'b0;
    cyc(8);
  endtask : done_op
  task automatic power_cycle;
    i_rst_n = 1'b0;
    cyc(20);
    i_rst_n = 1'b1;
    cyc(2);
  endtask : power_cycle
  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask : test_end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  initial begin
    #200us;
    miscompares++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    int i;
    int n;
    logic [15:0] ce_tab [4];
    logic [3:0]  ce_ok;
    ce_tab = '{16'h1C00, 16'h1C40, 16'h0000, 16'h0040};
    ce_ok = 4'b0110;
    i_rst_n = 1'b0;
    i_wp_n = 1'b1;
    i_op_done = 1'b0;
    power_cycle();
    check("reset status", status, 16'h0000);
    check("reset quad", quad_pins, 1'b0);
    send({CMD_STATUS_WRITE_CMD, 8'h1C, 8'h00, 16'h0}, 3);
    cyc(WCYC + 10);
    check("refused count", 24'(ref_cnt), 24'd1);
    check("status kept", status, 16'h0000);
    op1(CMD_WRITE_ENABLE_CMD);
    check("latch set", status, 16'h0002);
    u_host.frame({CMD_RDLO, 32'h0}, 1, 1, rd);
    cyc(12);
    check("low byte read", rd, 8'h02);
    op1(CMD_WRDI);
    check("latch cleared", status, 16'h0000);
    test_end("latch");
    op1(CMD_WRITE_ENABLE_CMD);
    u_host.frame({CMD_STATUS_WRITE_CMD, 8'h04, 8'h40, 16'h0}, 3, 0, rd);
    cyc(6);
    check("busy in write", status[0], 1'b1);
    cyc(WCYC + 8);
    check("written", status, 16'h4004);
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_SE, 24'h000000, 8'h0}, 4);
    check("low refused", 24'(ref_cnt), 24'd2);
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_SE, 24'h3F0000, 8'h0}, 4);
    check("top erase kind", last_kind, FSP_OP_ERASE);
    check("top erase addr", last_addr, 24'h3F0000);
    check("busy no latch", status[1:0], 2'b01);
    done_op();
    check("idle", status[0], 1'b0);
    test_end("protect");
    for (i = 0; i < 4; i++) begin
      status_write_cmd(ce_tab[i][15:8], ce_tab[i][7:0]);
      n = start_cnt;
      op1(CMD_WRITE_ENABLE_CMD);
      op1(i[0] ? CMD_CE2 : CMD_CE1);
      check("chip erase", 24'(start_cnt - n), 24'(ce_ok[i]));
      if (ce_ok[i]) begin
        check("chip kind", last_kind, FSP_OP_CHIP);
        done_op();
      end
    end
    test_end("chip");
    status_write_cmd(8'h80, 8'h00);
    check("mode 01", status, 16'h0080);
    i_wp_n = 1'b0;
    cyc(6);
    n = ref_cnt;
    status_write_cmd(8'h04, 8'h00);
    check("pin lock", status, 16'h0082);
    check("pin refused", 24'(ref_cnt - n), 24'd1);
    i_wp_n = 1'b1;
    cyc(6);
    status_write_cmd(8'h00, 8'h00);
    check("pin open", status, 16'h0000);
    status_write_cmd(8'h00, 8'h01);
    check("mode 10", status, 16'h0100);
    status_write_cmd(8'h00, 8'h00);
    check("mode 10 lock", status, 16'h0102);
    power_cycle();
    check("mode after power", status[8:7], 2'b00);
    test_end("modes");
    status_write_cmd(8'h00, 8'h0A);
    check("lock quad", status, 16'h0A00);
    check("quad pins", {quad_pins, quad_ok}, 2'b11);
    u_host.frame({CMD_RDHI, 32'h0}, 1, 1, rd);
    cyc(12);
    check("high byte read", rd, 8'h0A);
    status_write_cmd(8'h00, 8'h00);
    check("lock kept", status, 16'h0800);
    check("quad off", {quad_pins, quad_ok}, 2'b00);
    n = ref_cnt;
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_QPP, 24'h000200, 8'h5A}, 5);
    check("quad refused", 24'(ref_cnt - n), 24'd1);
    status_write_cmd(8'h00, 8'h02);
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_QPP, 24'h000200, 8'h5A}, 5);
    check("quad kind", last_kind, FSP_OP_PROG);
    check("quad addr", last_addr, 24'h000200);
    done_op();
    status_write_cmd(8'h64, 8'h00);
    check("sector sel", status, 16'h0864);
    n = ref_cnt;
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_BE32, 24'h000000, 8'h00}, 4);
    check("sector refused", 24'(ref_cnt - n), 24'd1);
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_BE64, 24'h001000, 8'h00}, 4);
    check("next sector", last_addr, 24'h001000);
    done_op();
    status_write_cmd(8'h00, 8'h00);
    test_end("lock");
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_PP, 24'h000100, 8'hA5}, 5);
    check("program kind", last_kind, FSP_OP_PROG);
    check("program addr", last_addr, 24'h000100);
    op1(CMD_SUSP);
    check("prog paused", status[10], 1'b1);
    op1(CMD_RESUME);
    check("prog resumed", status[10], 1'b0);
    done_op();
    op1(CMD_WRITE_ENABLE_CMD);
    send({CMD_SE, 24'h001000, 8'h0}, 4);
    op1(CMD_SUSP);
    check("erase paused", status[15], 1'b1);
    op1(CMD_RSTEN);
    op1(CMD_RST);
    check("reset unpause", status[15], 1'b0);
    done_op();
    test_end("suspend");
    status_write_cmd(8'h80, 8'h01);
    n = ref_cnt;
    status_write_cmd(8'h00, 8'h00);
    check("otp kept", status[8:7], 2'b11);
    check("otp refused", 24'(ref_cnt - n), 24'd1);
    test_end("otp");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
